// [inc/occ_pkg.sv]
/*
  Shared constants and types for the output compare channel.
  Assumes a 32-bit plain register port with one-cycle strobes.
*/
package occ_pkg;
  // Register map
  localparam logic [3:0] OCC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] OCC_ADDR_PRI = 4'h4;
  localparam logic [3:0] OCC_ADDR_SEC = 4'h8;
  // Control field positions
  localparam int OCC_BIT_ON = 15;
  localparam int OCC_BIT_IDLE = 13;
  localparam int OCC_BIT_WIDE = 5;
  localparam int OCC_BIT_FLT = 4;
  localparam int OCC_BIT_TSEL = 3;
  localparam int OCC_MODE_HI = 2;
  localparam logic [31:0] OCC_CTRL_WMASK = 32'h0000_A02F;
  localparam logic [31:0] OCC_ZERO32 = 32'h0000_0000;
  localparam logic [15:0] OCC_ZERO16 = 16'h0000;
  // Compare modes
  typedef enum logic [2:0] {
    OCC_M_OFF = 3'h0,
    OCC_M_SET_HI = 3'h1,
    OCC_M_SET_LO = 3'h2,
    OCC_M_TOGGLE = 3'h3,
    OCC_M_ONE_PULSE = 3'h4,
    OCC_M_PULSES = 3'h5,
    OCC_M_PWM = 3'h6,
    OCC_M_PWM_FLT = 3'h7
  } occ_mode_e;
  // Channel phase, one-hot
  typedef enum logic [2:0] {
    OCC_ST_IDLE = 3'b001,
    OCC_ST_RUN = 3'b010,
    OCC_ST_DONE = 3'b100
  } occ_state_e;
  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } occ_bus_s;
  // Module state, apart from the match flop and the synchronisers
  typedef struct packed {
    logic on;
    logic idle_stop;
    logic wide;
    logic flt;
    logic tsel;
    logic [2:0] mode;
    logic [31:0] pri;
    logic [31:0] sec;
    logic [31:0] rdata;
    logic pin;
    logic [2:0] mode_seen;
    logic on_seen;
    occ_state_e st;
  } occ_state_s;
endpackage : occ_pkg

// [hw/occ_top.sv]
/*
  Output compare channel: one control register, two compare values and
  the logic that drives the compare output pin from a selected timer count.
  Holds the reset release, the fault pin synchroniser, the next-state logic
  and the state register.
  Assumes both timer counts, the idle level and the register port come from
  other logic on clk_sys_in and need no synchroniser; the fault pin is
  asynchronous and is synchronised here; the register master never raises
  both strobes in one cycle and keeps one quiet cycle after clearing enable.
  Assumes the package gives the register offsets, field positions and types.
*/
// The implementer's own choices: the address-and-strobe port and the register addresses.
// Contract
// - Control bit 15 switches the channel on when set, off when clear.
// - Bit 13 set halts the channel in idle mode; clear keeps it running.
// - Bit 5 set compares 32 bits against 32-bit timer, else low 16 bits.
// - Fault flag bit 4 set on PWM fault; software writes never clear it (here a write that changes the mode or clears bit 15 clears it).
// - Fault flag reads zero unless mode is PWM with fault.
// - Bit 3 picks third timer when set, second timer when clear.
// - Mode 111 gives PWM; asserted fault stops output and sets flag.
// - Mode 110 gives PWM ignoring the fault input.
// - Mode 101 drives pin low, then a repeating pulse train.
// - Mode 100 drives pin low, then exactly one pulse.
// - Mode 011 toggles the pin on each compare match.
// - Mode 010 drives pin high, then low on compare match.
// - Mode 001 drives pin low, then high on compare match.
// - Mode 000 leaves compare inactive.
// - Control bits 31-16, 14 and 12-6 read as zero.
`timescale 1ns/1ps
module occ_top
  import occ_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Timer counts and device state
  input wire logic [31:0] timer2_count_in,
  input wire logic [31:0] timer3_count_in,
  input wire logic idle_mode_in,
  // Fault pin, asynchronous
  input wire logic pwm_fault_in,
  // Output pin and match pulse
  output logic compare_output_pin_out,
  output logic match_out
);

  occ_state_s s_r;
  occ_state_s s_nxt;
  occ_bus_s bus;
  logic [1:0] rst_sync_r;
  logic rst_b;
  logic flt_meta_r;
  logic flt_sync_r;
  logic match_r;
  logic match_nxt;

  // Register select codes, one-hot, from the shared address decoder
  localparam logic [2:0] SEL_NONE = 3'b000;
  localparam logic [2:0] SEL_CTRL = 3'b001;
  localparam logic [2:0] SEL_PRI = 3'b010;
  localparam logic [2:0] SEL_SEC = 3'b100;

  // Whole state after reset: channel off, pin low, values cleared
  localparam occ_state_s OCC_STATE_RST = '{
    on: 1'b0,
    idle_stop: 1'b0,
    wide: 1'b0,
    flt: 1'b0,
    tsel: 1'b0,
    mode: OCC_M_OFF,
    pri: OCC_ZERO32,
    sec: OCC_ZERO32,
    rdata: OCC_ZERO32,
    pin: 1'b0,
    mode_seen: OCC_M_OFF,
    on_seen: 1'b0,
    st: OCC_ST_IDLE
  };

  // 16-bit or 32-bit equality
  function automatic logic occ_eq(input logic wide, input logic [31:0] a,
                                  input logic [31:0] b);
    occ_eq = wide ? (a == b) : (a[15:0] == b[15:0]);
  endfunction : occ_eq

  // Address decode, shared by the write and the read path
  function automatic logic [2:0] occ_sel(input logic [3:0] addr);
    logic [2:0] sel;
    sel = SEL_NONE;
    if (addr == OCC_ADDR_CTRL) begin
      sel = SEL_CTRL;
    end else if (addr == OCC_ADDR_PRI) begin
      sel = SEL_PRI;
    end else if (addr == OCC_ADDR_SEC) begin
      sel = SEL_SEC;
    end
    occ_sel = sel;
  endfunction : occ_sel

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Reset release through two flops; assertion stays asynchronous
  // Synchronous release so no flop leaves reset a cycle apart
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_r[1];

  // Fault pin synchroniser; first flop feeds only the second
  // Level only: a fault shorter than a clock may be missed
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      flt_meta_r <= 1'b0;
      flt_sync_r <= 1'b0;
    end else begin
      flt_meta_r <= pwm_fault_in;
      flt_sync_r <= flt_meta_r;
    end
  end

  // Next-state logic
  // Priority: disable, then re-initialise after a change, then the mode;
  // register writes land last so software always wins over the channel
  always_comb begin
    logic [31:0] cnt;
    logic run;
    logic hit_pri;
    logic hit_sec;
    logic restart;
    logic [31:0] ctrl_rd;
    logic [2:0] sel;
    cnt = 32'h0;
    run = 1'b0;
    hit_pri = 1'b0;
    hit_sec = 1'b0;
    restart = 1'b0;
    ctrl_rd = 32'h0;
    sel = SEL_NONE;
    s_nxt = s_r;
    match_nxt = 1'b0;

    // Counts are used as they arrive; no capture or hold
    // timer source choice
    cnt = s_r.tsel ? timer3_count_in : timer2_count_in;
    // Halting freezes the pin except for the re-initialise after a mode or enable change; register writes still land
    // enable gate; idle halt; mode 000 inactive
    run = s_r.on && !(s_r.idle_stop && idle_mode_in) && (s_r.mode != OCC_M_OFF);
    // Secondary compared at the same width as primary
    // width select; primary match
    hit_pri = run && occ_eq(s_r.wide, cnt, s_r.pri);
    hit_sec = run && occ_eq(s_r.wide, cnt, s_r.sec);
    // One-cycle pulse, not held until read
    match_nxt = hit_pri;
    // Mode change or enable edge re-initialises the pin
    restart = (s_r.mode != s_r.mode_seen) || (s_r.on != s_r.on_seen);
    s_nxt.mode_seen = s_r.mode;
    s_nxt.on_seen = s_r.on;

    if (!s_r.on) begin
      // Disabling resets the channel, registers kept for software
      s_nxt.pin = 1'b0;
      s_nxt.flt = 1'b0;
      s_nxt.st = OCC_ST_IDLE;
    end else if (restart) begin
      s_nxt.pin = (s_r.mode == OCC_M_SET_LO);
      s_nxt.st = OCC_ST_RUN;
      // a fault already present sets the flag at once
      s_nxt.flt = run && (s_r.mode == OCC_M_PWM_FLT) && flt_sync_r;
    end else if (run) begin
      // Only the selected mode moves the pin; a mode change restarts first
      case (occ_mode_e'(s_r.mode))
        OCC_M_SET_HI: begin
          if (hit_pri) begin
            s_nxt.pin = 1'b1;
          end
        end
        OCC_M_SET_LO: begin
          if (hit_pri) begin
            s_nxt.pin = 1'b0;
          end
        end
        OCC_M_TOGGLE: begin
          if (hit_pri) begin
            s_nxt.pin = !s_r.pin;
          end
        end
        // one pulse, then stay low
        // Done keeps the pin low until a mode or enable change
        OCC_M_ONE_PULSE: begin
          if (s_r.st == OCC_ST_RUN) begin
            // rise on primary, fall on secondary
            if (hit_sec && s_r.pin) begin
              s_nxt.pin = 1'b0;
              s_nxt.st = OCC_ST_DONE;
            end else if (hit_pri) begin
              s_nxt.pin = 1'b1;
            end
          end
        end
        // repeating pulses; edges from the two values
        OCC_M_PULSES: begin
          if (hit_sec && s_r.pin) begin
            s_nxt.pin = 1'b0;
          end else if (hit_pri) begin
            s_nxt.pin = 1'b1;
          end
        end
        // PWM, fault ignored; high from primary to secondary
        // Secondary wins a tie, so equal values keep the pin low
        OCC_M_PWM: begin
          if (hit_sec) begin
            s_nxt.pin = 1'b0;
          end else if (hit_pri) begin
            s_nxt.pin = 1'b1;
          end
        end
        // PWM with fault; fault wins and latches until restart
        default: begin
          if (flt_sync_r || s_r.flt) begin
            s_nxt.flt = 1'b1;
            s_nxt.pin = 1'b0;
          end else if (hit_sec) begin
            s_nxt.pin = 1'b0;
          end else if (hit_pri) begin
            s_nxt.pin = 1'b1;
          end
        end
      endcase
    end

    // Register writes; fault flag is not writable
    // Unused and read-only bits are dropped here, never stored
    sel = occ_sel(bus.addr);
    if (bus.wr) begin
      if (sel == SEL_CTRL) begin
        // enable bit; flag bit masked from writes
        s_nxt.on = bus.wdata[OCC_BIT_ON] & OCC_CTRL_WMASK[OCC_BIT_ON];
        s_nxt.idle_stop = bus.wdata[OCC_BIT_IDLE];
        s_nxt.wide = bus.wdata[OCC_BIT_WIDE];
        s_nxt.tsel = bus.wdata[OCC_BIT_TSEL];
        s_nxt.mode = bus.wdata[OCC_MODE_HI:0];
      end else if (sel == SEL_PRI) begin
        s_nxt.pri = bus.wdata;
      end else if (sel == SEL_SEC) begin
        s_nxt.sec = bus.wdata;
      end
    end

    // unused control bits read zero; flag only in mode 111
    // Masked on read too, for the cycle before a mode change clears it
    ctrl_rd = OCC_ZERO32;
    ctrl_rd[OCC_BIT_ON] = s_r.on;
    ctrl_rd[OCC_BIT_IDLE] = s_r.idle_stop;
    ctrl_rd[OCC_BIT_WIDE] = s_r.wide;
    ctrl_rd[OCC_BIT_FLT] = s_r.flt && (s_r.mode == OCC_M_PWM_FLT);
    ctrl_rd[OCC_BIT_TSEL] = s_r.tsel;
    ctrl_rd[OCC_MODE_HI:0] = s_r.mode;

    // Read data valid only the cycle after the strobe
    // Zero outside that cycle so a stale word never looks valid
    s_nxt.rdata = OCC_ZERO32;
    if (bus.rd) begin
      if (sel == SEL_CTRL) begin
        s_nxt.rdata = ctrl_rd;
      end else if (sel == SEL_PRI) begin
        s_nxt.rdata = s_r.pri;
      end else if (sel == SEL_SEC) begin
        s_nxt.rdata = s_r.sec;
      end else begin
        s_nxt.rdata = OCC_ZERO32; // Unmapped reads zero
      end
    end
  end

  // State register
  // One struct, so every field shares the same reset and edge
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= OCC_STATE_RST;
      match_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      match_r <= match_nxt;
    end
  end

  // Outputs come straight from flops, no logic after them
  assign rdata_out = s_r.rdata;
  assign compare_output_pin_out = s_r.pin;
  assign match_out = match_r;

endmodule : occ_top

// [sim/occ_properties.sv]
/* Port checker for the compare channel.
   Assumes the register offsets and write mask of occ_pkg. */
`timescale 1ns/1ps
module occ_properties
  import occ_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // Timers, device state and pins
  input wire logic [31:0] timer2_count_in,
  input wire logic [31:0] timer3_count_in,
  input wire logic idle_mode_in,
  input wire logic pwm_fault_in,
  input wire logic compare_output_pin_out,
  input wire logic match_out
);
  logic [31:0] ctl_r;
  logic [31:0] pri_r;
  logic [1:0] wrq_r;
  logic [31:0] cnt;
  logic hit;
  logic quiet;
  logic [2:0] md;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // Shadow of software writes
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_r <= OCC_ZERO32;
      pri_r <= OCC_ZERO32;
      wrq_r <= 2'h0;
    end else begin
      wrq_r <= {wrq_r[0], wr_in};
      if (wr_in && addr_in == OCC_ADDR_CTRL) begin
        ctl_r <= wdata_in & OCC_CTRL_WMASK;
      end
      if (wr_in && addr_in == OCC_ADDR_PRI) begin
        pri_r <= wdata_in;
      end
    end
  end
  // Quiet skips the re-initialising cycles that follow any write
  assign cnt = ctl_r[OCC_BIT_TSEL] ? timer3_count_in : timer2_count_in;
  assign hit = ctl_r[OCC_BIT_WIDE] ? cnt == pri_r : cnt[15:0] == pri_r[15:0];
  assign quiet = wrq_r == 2'h0 && !wr_in && ctl_r[OCC_BIT_ON];
  assign md = ctl_r[2:0];
  a_unused_zero: assert property (rd_in && addr_in == OCC_ADDR_CTRL |=>
    (rdata_out & 32'hFFFF_5FC0) == OCC_ZERO32) else $error("unused bits set");
  a_ctl_readback: assert property (rd_in && addr_in == OCC_ADDR_CTRL |=>
    (rdata_out & OCC_CTRL_WMASK) == ctl_r) else $error("control readback wrong");
  a_match_follows: assert property (hit && quiet && md inside {3'h1, 3'h2, 3'h3}
    && !(ctl_r[OCC_BIT_IDLE] && idle_mode_in) |=> match_out) else $error("match missed");
  a_set_high: assert property (match_out && quiet && md == 3'h1 |->
    compare_output_pin_out) else $error("pin not high after match");
  a_set_low: assert property (match_out && quiet && md == 3'h2 |->
    !compare_output_pin_out) else $error("pin not low after match");
  a_toggle_pin: assert property (match_out && quiet && md == 3'h3 |->
    compare_output_pin_out != $past(compare_output_pin_out)) else $error("pin not toggled");
  a_idle_hold: assert property (quiet && ctl_r[OCC_BIT_IDLE] && idle_mode_in
    && $past(idle_mode_in) && md != 3'h7 |-> $stable(compare_output_pin_out))
    else $error("pin moved while halted");
  a_fault_stop: assert property ((ctl_r[OCC_BIT_ON] && md == 3'h7 && pwm_fault_in) [*3]
    |-> ##[1:2] !compare_output_pin_out) else $error("fault did not stop pin");
  // Main scenarios reached
  c_match: cover property (match_out && quiet);
  c_fault: cover property (md == 3'h7 && pwm_fault_in);
  c_idle: cover property (ctl_r[OCC_BIT_IDLE] && idle_mode_in);
endmodule : occ_properties

bind occ_top occ_properties u_props (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .timer2_count_in(timer2_count_in),
  .timer3_count_in(timer3_count_in), .idle_mode_in(idle_mode_in),
  .pwm_fault_in(pwm_fault_in), .compare_output_pin_out(compare_output_pin_out),
  .match_out(match_out));

// [sim/occ_timer_model.sv]
/* Timer model: two up counters wrapping at PERIOD.
   Assumes the channel clock and reset. */
`timescale 1ns/1ps
module occ_timer_model #(
  parameter int PERIOD = 64
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Counts
  output logic [31:0] timer2_count_out,
  output logic [31:0] timer3_count_out
);
  // Third timer half a period ahead, so a wrong source is seen
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer2_count_out <= 32'h0000_0000;
      timer3_count_out <= 32'(PERIOD / 2);
    end else begin
      timer2_count_out <= (timer2_count_out + 32'h1) % 32'(PERIOD);
      timer3_count_out <= (timer3_count_out + 32'h1) % 32'(PERIOD);
    end
  end
endmodule : occ_timer_model

// [sim/occ_top_tb.sv]
/* Bench: register cases, then table rows, then pulse and fault cases.
   Assumes the timer model wraps every PER cycles. */
`timescale 1ns/1ps
module occ_top_tb
  import occ_pkg::*;
;
  typedef struct {logic [15:0] ctl; logic t3; logic idle; logic [15:0] hi; logic exp;} occ_row_s;
  localparam int PER = 64;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic idle_mode_in = 1'b0;
  logic pwm_fault_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic [31:0] rdata_out, t2, t3, rd_v;
  logic compare_output_pin_out, match_out;
  int failures = 0;
  int n_checks = 0;
  occ_row_s rows [11];
  occ_timer_model #(.PERIOD(PER)) u_tmr (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .timer2_count_out(t2), .timer3_count_out(t3));
  occ_top dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .timer2_count_in(t2), .timer3_count_in(t3), .idle_mode_in(idle_mode_in),
    .pwm_fault_in(pwm_fault_in), .compare_output_pin_out(compare_output_pin_out),
    .match_out(match_out));
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in) wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in) rd_in <= 1'b0;
    #1 rd_v = rdata_out;
  endtask : rd
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_w
  task automatic pin_at(input int n, input logic e);
    repeat (n) @(posedge clk_sys_in);
    #1 chk_w({31'h0, compare_output_pin_out}, {31'h0, e});
  endtask : pin_at
  // Primary match 20 counts ahead, secondary 16 later
  task automatic run(input logic [15:0] c, input logic t, input logic [15:0] h);
    logic [31:0] b;
    #1 b = t ? t3 : t2;
    wr(OCC_ADDR_CTRL, OCC_ZERO32);
    wr(OCC_ADDR_PRI, {h, 16'((b + 20) % PER)});
    wr(OCC_ADDR_SEC, {h, 16'((b + 36) % PER)});
    wr(OCC_ADDR_CTRL, {OCC_ZERO16, c});
  endtask : run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // Clock
  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // Hang guard, far beyond the fewer than a thousand cycles needed
  initial begin
    #100000;
    failures++;
    close_out();
  end
  // Main sequence
  initial begin
    rows = '{'{16'h8001, 0, 0, 0, 1}, '{16'h8002, 0, 0, 0, 0}, '{16'h8003, 0, 0, 0, 1},
      '{16'h8009, 1, 0, 0, 1}, '{16'h8001, 1, 0, 0, 0}, '{16'h8001, 0, 0, 16'h5, 1},
      '{16'h8021, 0, 0, 16'h5, 0}, '{16'h0001, 0, 0, 0, 0}, '{16'h8000, 0, 0, 0, 0},
      '{16'hA001, 0, 1, 0, 0}, '{16'h8001, 0, 1, 0, 1}};
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(OCC_ADDR_CTRL);
    chk_w(rd_v, OCC_ZERO32);
    wr(OCC_ADDR_CTRL, 32'hFFFF_FFFF);
    rd(OCC_ADDR_CTRL);
    chk_w(rd_v, 32'h0000_A02F);
    rd(4'hC);
    chk_w(rd_v, OCC_ZERO32);
    $display("register test done");
    foreach (rows[i]) begin
      @(posedge clk_sys_in) idle_mode_in <= rows[i].idle;
      run(rows[i].ctl, rows[i].t3, rows[i].hi);
      pin_at(36, rows[i].exp);
      rd(OCC_ADDR_CTRL);
      chk_w(rd_v, {OCC_ZERO16, rows[i].ctl} & OCC_CTRL_WMASK);
      $display("row %0d done", i);
    end
    // Pulse and PWM modes; fault held high in mode 6
    for (int m = 4; m < 7; m++) begin
      @(posedge clk_sys_in);
      idle_mode_in <= 1'b0;
      pwm_fault_in <= (m == 6);
      run(16'h8000 | 16'(m), 1'b0, OCC_ZERO16);
      repeat (13) @(posedge clk_sys_in);
      #1 chk_w({31'h0, match_out}, 32'h0000_0001);
      pin_at(8, 1'b1);
      pin_at(15, 1'b0);
      pin_at(50, m != 4);
      $display("pulse mode %0d done", m);
    end
    @(posedge clk_sys_in) pwm_fault_in <= 1'b0;
    run(16'h8007, 1'b0, OCC_ZERO16);
    pin_at(21, 1'b1);
    @(posedge clk_sys_in) pwm_fault_in <= 1'b1;
    pin_at(5, 1'b0);
    @(posedge clk_sys_in) pwm_fault_in <= 1'b0;
    rd(OCC_ADDR_CTRL);
    chk_w(rd_v, 32'h0000_8017);
    wr(OCC_ADDR_CTRL, 32'h0000_8007);
    rd(OCC_ADDR_CTRL);
    chk_w(rd_v, 32'h0000_8017);
    // Read right behind the mode change, while the flag is still held
    @(posedge clk_sys_in);
    addr_in <= OCC_ADDR_CTRL;
    wdata_in <= 32'h0000_8006;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge clk_sys_in) rd_in <= 1'b0;
    #1 chk_w(rdata_out, 32'h0000_8006);
    $display("fault test done");
    close_out();
  end
endmodule : occ_top_tb
